// [logic/oag_pkg.sv]
package oag_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  // The printed offset is not word aligned, so it is kept as the register index
  // and the register owns the whole word at four times that index
  localparam logic [31:0] PAGE_SEL_ADDR  = 32'h0000_00f3;
  localparam logic [31:0] PAGE_SEL_BYTE  = PAGE_SEL_ADDR << 2;
  localparam logic [7:0]  PAGE_SEL_RESET = 8'h00;
  localparam logic [31:0] STATUS_BYTE    = 32'h0000_00f4;
  localparam logic [7:0]  ZERO_PAGE      = 8'h00;

  // --------------------------------------------------------------------------
  // AHB-Lite encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // --------------------------------------------------------------------------
  // Addressing modes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_REG      = 4'h0,
    MODE_IMM      = 4'h1,
    MODE_DP       = 4'h2,
    MODE_ABS      = 4'h3,
    MODE_ABS_RMW  = 4'h4,
    MODE_X_INC    = 4'h5,
    MODE_X        = 4'h6,
    MODE_DP_X     = 4'h7,
    MODE_DP_Y     = 4'h8,
    MODE_ABS_Y    = 4'h9,
    MODE_DP_IND   = 4'ha
  } addr_mode_e;

  // Selector for the register operand
  typedef enum logic [2:0] {
    REG_ACC = 3'h0,
    REG_X   = 3'h1,
    REG_Y   = 3'h2,
    REG_C   = 3'h3,
    REG_PSW = 3'h4
  } core_reg_e;

  // Request from instruction decode
  typedef struct packed {
    logic       valid;
    addr_mode_e mode;
    core_reg_e  reg_sel;
    logic [7:0] op1;
    logic [7:0] op2;
  } oag_req_s;

  // Answer toward data memory and register file
  typedef struct packed {
    logic        valid;
    logic        mem_access;
    logic        is_reg;
    core_reg_e   reg_sel;
    logic        is_imm;
    logic [7:0]  imm_data;
    logic [15:0] addr;
    logic        x_inc;
    logic [7:0]  x_next;
    logic        is_target;
    logic [15:0] target;
  } oag_rsp_s;

  // Pointer fetch handshake with data memory
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } ptr_rd_s;

  // Indirect fetch states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LO   = 3'b010,
    ST_HI   = 3'b100
  } ind_state_e;

endpackage : oag_pkg

// [logic/operand_address_generator.sv]
// Summary of operation
// [R1] Register mode selects A, X, Y, C or PSW; no memory access.
// [R2] Immediate mode passes the second byte as data, no lookup.
// [R3] With paging on, address is page register high byte, instruction byte low.
// [R4] With paging off, direct page is always page zero.
// [R5] Direct page mode uses the operand byte as offset in the page.
// [R6] Absolute mode takes second byte low, third byte high.
// [R7] Absolute read-modify-write uses full address, ignoring paging.
// [R8] Auto-increment mode addresses X in direct page, then X plus 1.
// [R9] Indexed mode without offset addresses X inside the direct page.
// [R10] X-indexed direct page adds operand to X within the page.
// [R11] Y-indexed direct page adds operand to Y within the page.
// [R12] Y-indexed absolute adds Y to the 16-bit address.
// [R13] Direct page indirect reads a byte pair as the jump target.
// [R14] Direct page offset sums wrap to 8 bits, no page carry.
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator
  import oag_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Core side
  input  wire logic        paging_flag,
  input  wire logic [7:0]  x_index,
  input  wire logic [7:0]  y_index,
  input  wire oag_req_s    req,
  output var  oag_rsp_s    rsp,
  output var  logic        busy,
  output var  ptr_rd_s     ptr_rd,
  input  wire logic        ptr_valid,
  input  wire logic [7:0]  ptr_data
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    oag_rsp_s    rsp;
    ind_state_e  ind;
    logic [7:0]  ptr_off;
    logic [7:0]  ptr_page;
    logic [7:0]  tgt_lo;
    ptr_rd_s     ptr_rd;
    logic        busy;
  } oag_state_s;

  oag_state_s state_q;
  oag_state_s state_d;

  logic [7:0] page_q;
  logic       page_wr;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Page that a direct page access lands in
  function automatic logic [7:0] dp_page(input logic gflag, input logic [7:0] page);
    dp_page = gflag ? page : ZERO_PAGE;   // [R3] [R4]
  endfunction : dp_page

  // Direct page address from an 8-bit offset; the offset never carries out
  function automatic logic [15:0] dp_addr(input logic [7:0] page, input logic [7:0] off);
    dp_addr = {page, off};                // [R3] [R5] [R14]
  endfunction : dp_addr

  // Word-aligned register decode
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] base);
    addr_hit = (a[31:2] == base[31:2]);
  endfunction : addr_hit

  // --------------------------------------------------------------------------
  // Page register
  // --------------------------------------------------------------------------
  page_select_reg u_page (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (page_wr),
    .wr_data (hwdata[7:0]),
    .page_q  (page_q)
  );

  // The page register owns a whole word; only its low byte is stored
  assign page_wr = state_q.wr_pend && addr_hit(state_q.wr_addr, PAGE_SEL_BYTE);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic       acc;
    logic [7:0] pg;
    logic [7:0] sum;
    acc = 1'b0;
    pg  = 8'h00;
    sum = 8'h00;
    state_d = state_q;

    // AHB address phase; writes land in the following data phase
    acc = hsel && hready && (htrans == HTRANS_NONSEQ);
    state_d.wr_pend = acc && hwrite;
    if (acc) begin
      state_d.wr_addr = haddr;
    end
    if (acc && !hwrite) begin
      if (addr_hit(haddr, PAGE_SEL_BYTE)) begin
        state_d.rdata = {24'h00_0000, page_q};
      end else if (addr_hit(haddr, STATUS_BYTE)) begin
        // Live view of the block: paging flag, fetch busy, last address
        state_d.rdata = {14'h0000, state_q.busy, paging_flag, state_q.rsp.addr};
      end else begin
        state_d.rdata = 32'h0000_0000;    // Unmapped reads return zero
      end
    end

    // Decode answer stands for one cycle only
    state_d.rsp.valid  = 1'b0;
    state_d.rsp.x_inc  = 1'b0;
    state_d.ptr_rd.rd  = 1'b0;
    pg = dp_page(paging_flag, page_q);

    unique case (state_q.ind)
      ST_IDLE: begin
        if (req.valid) begin
          state_d.rsp = '0;
          state_d.rsp.valid = 1'b1;
          unique case (req.mode)
            MODE_REG: begin
              state_d.rsp.is_reg  = 1'b1;                 // [R1]
              state_d.rsp.reg_sel = req.reg_sel;          // [R1]
            end
            MODE_IMM: begin
              state_d.rsp.is_imm   = 1'b1;                // [R2]
              state_d.rsp.imm_data = req.op1;             // [R2]
            end
            MODE_DP: begin
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = dp_addr(pg, req.op1);    // [R5]
            end
            MODE_ABS, MODE_ABS_RMW: begin
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = {req.op2, req.op1};      // [R6] [R7]
            end
            MODE_X_INC: begin
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr   = dp_addr(pg, x_index);  // [R8]
              state_d.rsp.x_inc  = 1'b1;                  // [R8]
              state_d.rsp.x_next = x_index + 8'h01;       // [R8]
            end
            MODE_X: begin
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = dp_addr(pg, x_index);    // [R9]
            end
            MODE_DP_X: begin
              sum = req.op1 + x_index;                    // [R10] [R14]
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = dp_addr(pg, sum);        // [R10]
            end
            MODE_DP_Y: begin
              sum = req.op1 + y_index;                    // [R11] [R14]
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = dp_addr(pg, sum);        // [R11]
            end
            MODE_ABS_Y: begin
              state_d.rsp.mem_access = 1'b1;
              state_d.rsp.addr = {req.op2, req.op1} + {8'h00, y_index}; // [R12]
            end
            MODE_DP_IND: begin
              // Pointer fetch: answer waits for both bytes
              state_d.rsp.valid = 1'b0;
              state_d.ptr_off   = req.op1;
              state_d.ptr_page  = pg;
              state_d.ptr_rd.rd   = 1'b1;                       // [R13]
              state_d.ptr_rd.addr = dp_addr(pg, req.op1);       // [R13]
              state_d.busy = 1'b1;
              state_d.ind  = ST_LO;
            end
            default: begin
              state_d.rsp.valid = 1'b0;   // Illegal mode code is ignored
            end
          endcase
        end
      end
      ST_LO: begin
        state_d.ptr_rd.rd = !ptr_valid;
        if (ptr_valid) begin
          state_d.tgt_lo = ptr_data;
          // Second pointer byte stays inside the page
          state_d.ptr_rd.rd   = 1'b1;
          state_d.ptr_rd.addr = dp_addr(state_q.ptr_page, state_q.ptr_off + 8'h01); // [R14]
          state_d.ind = ST_HI;
        end
      end
      ST_HI: begin
        state_d.ptr_rd.rd = !ptr_valid;
        if (ptr_valid) begin
          state_d.rsp = '0;
          state_d.rsp.valid     = 1'b1;
          state_d.rsp.is_target = 1'b1;
          state_d.rsp.target    = {ptr_data, state_q.tgt_lo};     // [R13]
          state_d.rsp.addr      = {ptr_data, state_q.tgt_lo};
          state_d.busy = 1'b0;
          state_d.ind  = ST_IDLE;
        end
      end
      default: begin
        state_d.ind  = ST_IDLE;
        state_d.busy = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '{wr_pend: 1'b0, wr_addr: 32'h0000_0000, rdata: 32'h0000_0000,
                   rsp: '0, ind: ST_IDLE, ptr_off: 8'h00, ptr_page: 8'h00,
                   tgt_lo: 8'h00, ptr_rd: '0, busy: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops, hreadyout and hresp tied off; the slave never inserts wait states
  assign hrdata    = state_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rsp       = state_q.rsp;
  assign busy      = state_q.busy;
  assign ptr_rd    = state_q.ptr_rd;

endmodule : operand_address_generator
`default_nettype wire

// [logic/page_select_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module page_select_reg
  import oag_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output var  logic [7:0] page_q
);

  typedef struct packed {
    logic [7:0] page;
  } page_state_s;

  page_state_s state_q;
  page_state_s state_d;

  // Next page value on a write
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.page = wr_data;
    end
  end

  // Page register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '{page: PAGE_SEL_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign page_q = state_q.page;

endmodule : page_select_reg
`default_nettype wire

// [tb/oag_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module oag_chk
  import oag_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       paging_flag,
  input wire logic [7:0] x_index,
  input wire logic [7:0] y_index,
  input wire oag_req_s   req,
  input wire oag_rsp_s   rsp,
  input wire logic       busy,
  input wire ptr_rd_s    ptr_rd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Request taken in one mode; a busy core drops requests
  // ----------------------------------------------------------------
  function automatic logic tk(oag_req_s r, logic b, addr_mode_e m);
    return r.valid && !b && r.mode == m;
  endfunction : tk
  AST_REG: assert property (tk(req, busy, MODE_REG) |=> rsp.valid && rsp.is_reg
    && !rsp.mem_access && rsp.reg_sel == $past(req.reg_sel)) else $error("bad reg op");
  AST_IMM: assert property (tk(req, busy, MODE_IMM) |=> rsp.is_imm
    && !rsp.mem_access && rsp.imm_data == $past(req.op1)) else $error("bad imm");
  AST_DP: assert property (tk(req, busy, MODE_DP) && !paging_flag |=>
    rsp.addr == {ZERO_PAGE, $past(req.op1)}) else $error("bad dp");
  AST_ABS: assert property (tk(req, busy, MODE_ABS) |=>
    rsp.addr == {$past(req.op2), $past(req.op1)}) else $error("bad abs");
  AST_RMW: assert property (tk(req, busy, MODE_ABS_RMW) |=>
    rsp.addr == {$past(req.op2), $past(req.op1)}) else $error("bad rmw");
  AST_XINC: assert property (tk(req, busy, MODE_X_INC) |=> rsp.x_inc
    && rsp.x_next == $past(x_index) + 8'h01) else $error("bad x step");
  AST_X: assert property (tk(req, busy, MODE_X) |=>
    rsp.addr[7:0] == $past(x_index)) else $error("bad x");
  AST_DPX: assert property (tk(req, busy, MODE_DP_X) && !paging_flag |=>
    rsp.addr == {ZERO_PAGE, $past(req.op1) + $past(x_index)}) else $error("bad dp x");
  AST_DPY: assert property (tk(req, busy, MODE_DP_Y) |=>
    rsp.addr[7:0] == $past(req.op1) + $past(y_index)) else $error("bad dp y");
  AST_ABSY: assert property (tk(req, busy, MODE_ABS_Y) |=>
    rsp.addr == {$past(req.op2), $past(req.op1)} + {8'h00, $past(y_index)}) else $error("bad y");
  AST_IND: assert property (tk(req, busy, MODE_DP_IND) && !paging_flag |=> busy
    && ptr_rd.rd && ptr_rd.addr == {ZERO_PAGE, $past(req.op1)}) else $error("bad fetch");
  // Main scenarios reached
  CV_IND: cover property (rsp.valid && rsp.is_target);
  CV_XINC: cover property (tk(req, busy, MODE_X_INC));
  CV_REG: cover property (tk(req, busy, MODE_REG));
endmodule : oag_chk
bind operand_address_generator oag_chk chk (.hclk(hclk), .hresetn(hresetn),
  .paging_flag(paging_flag), .x_index(x_index), .y_index(y_index), .req(req),
  .rsp(rsp), .busy(busy), .ptr_rd(ptr_rd));
`default_nettype wire

// [tb/operand_address_generator_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb_top
  import oag_pkg::*;
;
  logic hclk = 1'b0, hresetn, hsel, hwrite, hreadyout, hresp, paging_flag, busy, ptr_valid;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] x_index, y_index, ptr_data;
  logic [3:0] lat;
  oag_req_s req;
  oag_rsp_s rsp;
  ptr_rd_s ptr_rd;
  int fails = 0, samples_checked = 0;
  always #10 hclk = ~hclk;
  operand_address_generator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .paging_flag(paging_flag),
    .x_index(x_index), .y_index(y_index), .req(req), .rsp(rsp), .busy(busy),
    .ptr_rd(ptr_rd), .ptr_valid(ptr_valid), .ptr_data(ptr_data));
  ptr_mem mem (.hclk(hclk), .hresetn(hresetn), .ptr_rd(ptr_rd), .lat(lat),
    .ptr_valid(ptr_valid), .ptr_data(ptr_data));
  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Single AHB-Lite word transfer; waits on hready rather than assuming no waits
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : bus
  // One decode request; waits bounded for the answer pulse
  task automatic op(input addr_mode_e m, input logic [7:0] a, input logic [7:0] b,
                    input core_reg_e r = REG_ACC);
    int n;
    n = 0;
    @(posedge hclk);
    req <= '{1'b1, m, r, a, b};
    @(posedge hclk);
    req.valid <= 1'b0;
    // The answer pulse is read at the edge that ends it, before it changes
    do begin
      @(posedge hclk);
      n++;
    end while (rsp.valid !== 1'b1 && n < 40);
    if (rsp.valid !== 1'b1) fails++;
  endtask : op
  initial begin
    repeat (4000) @(posedge hclk);
    fails++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, paging_flag} = '0;
    {x_index, y_index, lat} = '0;
    req = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, PAGE_SEL_BYTE, 32'h0);
    check(q, {24'h00_0000, PAGE_SEL_RESET});
    bus(1'b0, 32'h0000_0080, 32'h0);
    check(q, 32'h0);
    bus(1'b1, PAGE_SEL_BYTE, 32'h0000_0001);
    bus(1'b0, PAGE_SEL_BYTE, 32'h0);
    check(q, 32'h0000_0001);
    op(MODE_DP, 8'h35, 8'h00);
    check(rsp.addr, 16'h0035);
    paging_flag <= 1'b1;
    op(MODE_DP, 8'h35, 8'h00);
    check(rsp.addr, 16'h0135);
    for (int i = 0; i < 5; i++) begin
      op(MODE_REG, 8'h00, 8'h00, core_reg_e'(i));
      check({rsp.is_reg, rsp.mem_access, rsp.reg_sel}, {2'b10, 3'(i)});
    end
    op(MODE_IMM, 8'ha7, 8'h00);
    check({rsp.is_imm, rsp.mem_access, rsp.imm_data}, {2'b10, 8'ha7});
    op(MODE_ABS, 8'h15, 8'h01);
    check(rsp.addr, 16'h0115);
    op(MODE_ABS_RMW, 8'h15, 8'h02);
    check(rsp.addr, 16'h0215);
    x_index <= 8'hff;
    op(MODE_X_INC, 8'h00, 8'h00);
    check({rsp.x_inc, rsp.x_next, rsp.addr}, {1'b1, 8'h00, 16'h01ff});
    x_index <= 8'h15;
    op(MODE_X, 8'h00, 8'h00);
    check(rsp.addr, 16'h0115);
    x_index <= 8'hf5;
    op(MODE_DP_X, 8'h45, 8'h00);
    check(rsp.addr, 16'h013a);
    y_index <= 8'hf0;
    op(MODE_DP_Y, 8'h20, 8'h00);
    check(rsp.addr, 16'h0110);
    y_index <= 8'h55;
    op(MODE_ABS_Y, 8'hf0, 8'hff);
    check(rsp.addr, 16'h0045);
    // Pointer at the page top: high byte wraps to offset zero of the same page
    for (int k = 0; k < 2; k++) begin
      lat <= 4'(3 * k);
      op(MODE_DP_IND, 8'hff, 8'h00);
      check({rsp.is_target, rsp.target}, {1'b1, 16'h5ba4});
    end
    // Status word: idle, paging on, last address is the fetched target
    bus(1'b0, STATUS_BYTE, 32'h0);
    check(q, 32'h0001_5ba4);
    // Paging off: offset sums and pointer fetch fall back to page zero
    paging_flag <= 1'b0;
    op(MODE_DP_X, 8'h45, 8'h00);
    check(rsp.addr, 16'h003a);
    op(MODE_DP_IND, 8'hff, 8'h00);
    check({rsp.is_target, rsp.target}, {1'b1, 16'h5aa5});
    complete_run();
  end
endmodule : operand_address_generator_tb_top
`default_nettype wire

// [tb/ptr_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module ptr_mem
  import oag_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire ptr_rd_s    ptr_rd,
  input  wire logic [3:0] lat,
  output var  logic       ptr_valid,
  output var  logic [7:0] ptr_data
);
  logic [3:0] cnt_q;
  // Answers a held read lat+1 cycles after it rises; idle data toggles so stale bytes never match
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      ptr_valid <= 1'b0;
      ptr_data <= 8'h00;
    end else if (ptr_valid || !ptr_rd.rd) begin
      ptr_valid <= 1'b0;
      cnt_q <= 4'h0;
      ptr_data <= ~ptr_data;
    end else if (cnt_q == lat) begin
      ptr_valid <= 1'b1;
      ptr_data <= ptr_rd.addr[7:0] ^ ptr_rd.addr[15:8] ^ 8'h5a;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : ptr_mem
`default_nettype wire
